/* rtl/tmc_cache.sv */
// How it works
// - miss fill goes into least recently used block
// - replacement bit zero names A, one B
// - after a fill, invert the class replacement bit
// - hit makes the other block least recent
// - invalid block never hits despite key match
// - clear opcode or console clear invalidates all
// - any block load clears its invalidity flag
// - index picks class, key compared both blocks
// - key parity odd over key and flag
// - word parity even over sixteen data bits
// - address split into key, index, word fields
// - word field picks word 0 to 3
// - fill start address is address masked
// - miss fetches four words into chosen block
// - valid matching block answers without memory
// - both blocks matching is reported as error
// - 256 classes, two blocks, four words each
// - one fill reads sixty-four bits
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
module tmc_cache #(
  parameter int NCLASS = 256
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite register slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // microsequencer fetch
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  output logic fetch_ack,
  output logic [15:0] fetch_word,
  // executed microinstruction and console
  input wire logic exec_valid,
  input wire logic [7:0] exec_opcode,
  input wire logic console_clear,
  input wire logic console_load,
  input wire logic [23:0] console_addr,
  input wire logic [63:0] console_block,
  // main memory fill port
  output logic mem_req,
  output logic [23:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [63:0] mem_block,
  // error and interrupt
  output logic processor_error_report,
  output logic irq
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (NCLASS != (1 << tmc_pkg::IDX_W))
    $error("class count must match the index field");

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  tmc_pkg::tmc_state_e state_q;
  logic [23:0] addr_q;                // captured fetch address
  logic src_sw_q;                     // request came from software
  logic [NCLASS-1:0] lru_q;           // one replacement bit per class
  logic clr_pend_q;                   // clear waiting for idle
  logic sw_pend_q;                    // software fetch waiting
  logic [23:0] mfp_q;                 // micro_fetch_pointer
  logic [16:0] fdata_q;               // software result and valid
  logic [tmc_pkg::STAT_W-1:0] stat_q; // sticky events
  logic [tmc_pkg::STAT_W-1:0] ien_q;  // interrupt enables
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic fetch_ack_q, mem_req_q, err_q, irq_q;
  logic [15:0] fetch_word_q;
  logic [23:0] mem_addr_q;

  // ----------------------------------------
  // address fields and lookup
  // ----------------------------------------
  wire [7:0] idx = addr_q[tmc_pkg::IDX_LSB +: tmc_pkg::IDX_W];
  wire [7:0] key = addr_q[tmc_pkg::KEY_LSB +: tmc_pkg::KEY_W];
  wire [1:0] wsel = addr_q[tmc_pkg::WSEL_LSB +: tmc_pkg::WSEL_W];
  wire look = (state_q == tmc_pkg::S_LOOK);
  wire is_idle = (state_q == tmc_pkg::S_IDLE);
  logic [1:0] hit_w, kerr_w, derr_w, we_w;
  logic [7:0] rkey [2];
  logic [15:0] rdat [2];
  logic [1:0] rinv, rkpar, rdpar;
  wire any_hit = |hit_w;
  wire dual = &hit_w;
  wire miss = ~any_hit;
  // dual match falls back to block a; the error report flags it
  wire [15:0] hit_word = hit_w[0] ? rdat[0] : rdat[1];
  wire perr = |((kerr_w | derr_w) & hit_w);

  // ----------------------------------------
  // request arbitration
  // ----------------------------------------
  wire [7:0] wr_a = awaddr_q;
  wire wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  wire ctrl_wr = wr_fire & (wr_a == tmc_pkg::REG_CTRL) & wstrb_q[0];
  wire clr_req = (exec_valid & (exec_opcode == tmc_pkg::OPC_CLEAR))
               | console_clear | (ctrl_wr & wdata_q[tmc_pkg::CTRL_CLEAR]);
  wire clr_fire = is_idle & (clr_pend_q | clr_req);
  wire ld_fire = is_idle & ~clr_fire & console_load;
  // the ack term stops a held request from being taken twice
  wire seq_take = is_idle & ~clr_fire & ~console_load & fetch_req & ~fetch_ack_q;
  wire sw_take = is_idle & ~clr_fire & ~console_load & ~fetch_req & sw_pend_q;
  wire fill_we = (state_q == tmc_pkg::S_FILL) & mem_ack;
  wire [7:0] w_idx = ld_fire ? console_addr[tmc_pkg::IDX_LSB +: tmc_pkg::IDX_W] : idx;
  wire [7:0] w_key = ld_fire ? console_addr[tmc_pkg::KEY_LSB +: tmc_pkg::KEY_W] : key;
  wire [63:0] w_blk = ld_fire ? console_block : mem_block;
  wire victim = lru_q[w_idx];
  wire w_kpar;
  logic [3:0] w_dpar;

  // key parity for a freshly loaded, valid block
  tmc_parity #(.W(9), .ODD(1'b1)) u_kpar (
    .data({w_key, 1'b0}),
    .par(w_kpar)
  );

  // ----------------------------------------
  // per-block storage and compare
  // ----------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : g_way
    wire dp;
    assign we_w[g] = (ld_fire | fill_we) & (victim == 1'(g));
    tmc_parity #(.W(16), .ODD(1'b0)) u_dpar (
      .data(w_blk[16*g +: 16]),
      .par(dp)
    );
    tmc_parity #(.W(16), .ODD(1'b0)) u_dpar_hi (
      .data(w_blk[16*(g+2) +: 16]),
      .par(w_dpar[g+2])
    );
    assign w_dpar[g] = dp;
    tmc_way #(.NCLASS(NCLASS)) u_way (
      .clk(clk),
      .resetn(resetn),
      .rd_idx(idx),
      .rd_word(wsel),
      .rd_key(rkey[g]),
      .rd_inv(rinv[g]),
      .rd_kpar(rkpar[g]),
      .rd_data(rdat[g]),
      .rd_dpar(rdpar[g]),
      .inv_all(clr_fire),
      .we(we_w[g]),
      .wr_idx(w_idx),
      .wr_key(w_key),
      .wr_kpar(w_kpar),
      .wr_block(w_blk),
      .wr_dpar(w_dpar)
    );
    // an invalid block is kept out of the hit vector
    assign hit_w[g] = ~rinv[g] & (rkey[g] == key);
    assign kerr_w[g] = ~(^{rkey[g], rinv[g], rkpar[g]});
    assign derr_w[g] = ^{rdat[g], rdpar[g]};
  end

  // ----------------------------------------
  // fetch sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= tmc_pkg::S_IDLE;
      addr_q <= '0;
      src_sw_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        tmc_pkg::S_IDLE:
        begin
          if (seq_take | sw_take)
          begin
            addr_q <= (sw_take ? mfp_q : fetch_addr) & tmc_pkg::ADDR_KEEP;
            src_sw_q <= sw_take;
            state_q <= tmc_pkg::S_LOOK;
          end
        end
        tmc_pkg::S_LOOK:
          // miss waits for the fill, then looks again
          state_q <= miss ? tmc_pkg::S_FILL : tmc_pkg::S_IDLE;
        tmc_pkg::S_FILL:
          if (mem_ack)
            state_q <= tmc_pkg::S_LOOK;
        default:
          state_q <= tmc_pkg::S_IDLE;
      endcase
    end
  end

  // replacement bits: a load flips, a single hit points away
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lru_q <= '0;
    else if (ld_fire | fill_we)
      lru_q[w_idx] <= ~lru_q[w_idx];
    else if (look & any_hit & ~dual)
      lru_q[idx] <= hit_w[0] ? tmc_pkg::LRU_B : tmc_pkg::LRU_A;
  end

  // answers to the sequencer, memory and error register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fetch_ack_q <= 1'b0;
      fetch_word_q <= '0;
      mem_req_q <= 1'b0;
      mem_addr_q <= '0;
      err_q <= 1'b0;
    end
    else
    begin
      fetch_ack_q <= look & any_hit & ~src_sw_q;
      if (look & any_hit)
        fetch_word_q <= hit_word;
      if (look & miss)
      begin
        mem_req_q <= 1'b1;
        mem_addr_q <= addr_q & tmc_pkg::FILL_MASK;
      end
      else if (mem_ack)
        mem_req_q <= 1'b0;
      err_q <= look & (dual | perr);
    end
  end

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire mfp_wr = wr_fire & (wr_a == tmc_pkg::REG_MFP);
  wire ien_wr = wr_fire & (wr_a == tmc_pkg::REG_IEN) & wstrb_q[0];
  wire iclr_wr = wr_fire & (wr_a == tmc_pkg::REG_ICLR) & wstrb_q[0];
  wire wr_ok = (wr_a == tmc_pkg::REG_MFP) | (wr_a == tmc_pkg::REG_IEN)
             | (wr_a == tmc_pkg::REG_ICLR) | (wr_a == tmc_pkg::REG_CTRL);
  wire [7:0] ra = s_axi_araddr;
  wire rd_ok = (ra == tmc_pkg::REG_MFP) | (ra == tmc_pkg::REG_FDATA)
             | (ra == tmc_pkg::REG_STAT) | (ra == tmc_pkg::REG_IEN)
             | (ra == tmc_pkg::REG_ICLR) | (ra == tmc_pkg::REG_CTRL);
  // write-only and unmapped words read as zero
  wire [31:0] rd_mux = (ra == tmc_pkg::REG_MFP) ? {8'h00, mfp_q}
                     : (ra == tmc_pkg::REG_FDATA) ? {15'h0000, fdata_q}
                     : (ra == tmc_pkg::REG_STAT) ? {27'h0000000, stat_q}
                     : (ra == tmc_pkg::REG_IEN) ? {27'h0000000, ien_q}
                     : 32'h00000000;
  wire [tmc_pkg::STAT_W-1:0] stat_set = {clr_fire, look & perr, look & dual,
                                         look & miss, look & any_hit};
  wire [tmc_pkg::STAT_W-1:0] stat_clr = iclr_wr ? wdata_q[tmc_pkg::STAT_W-1:0] : '0;

  // write channels: address and data taken in either order
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= tmc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & awready_q)
      begin
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid & wready_q)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? tmc_pkg::RESP_OKAY : tmc_pkg::RESP_SLVERR;
      end
      else if (bvalid_q & s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read channel: one word per address, answered next cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= tmc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid & arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? tmc_pkg::RESP_OKAY : tmc_pkg::RESP_SLVERR;
    end
    else if (rvalid_q & s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // software-visible state; a hardware set beats a same-cycle clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mfp_q <= '0;
      sw_pend_q <= 1'b0;
      clr_pend_q <= 1'b0;
      fdata_q <= '0;
      stat_q <= '0;
      ien_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      if (mfp_wr)
        mfp_q <= ((mfp_q & ~wmask[23:0]) | (wdata_q[23:0] & wmask[23:0])) & tmc_pkg::ADDR_KEEP;
      sw_pend_q <= mfp_wr | (sw_pend_q & ~sw_take);
      clr_pend_q <= (clr_pend_q | clr_req) & ~clr_fire;
      if (sw_take)
        fdata_q[tmc_pkg::FDATA_VALID] <= 1'b0;
      else if (look & any_hit & src_sw_q)
        fdata_q <= {1'b1, hit_word};
      if (ien_wr)
        ien_q <= wdata_q[tmc_pkg::STAT_W-1:0];
      stat_q <= stat_set | (stat_q & ~stat_clr);
      irq_q <= |(stat_q & ien_q);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign fetch_ack = fetch_ack_q;
  assign fetch_word = fetch_word_q;
  assign mem_req = mem_req_q;
  assign mem_addr = mem_addr_q;
  assign processor_error_report = err_q;
  assign irq = irq_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_fill_done;
    fill_we ##1 look;
  endsequence
  sequence s_clear_then_fetch;
    clr_fire ##[1:3] (seq_take | sw_take) ##1 look;
  endsequence

  AST_VICTIM: assert property (fill_we |-> we_w[lru_q[idx]] && !we_w[~lru_q[idx]])
    else $error("fill wrote the recently used block");
  AST_LRU_FLIP: assert property (fill_we |=> lru_q[$past(idx)] != $past(lru_q[idx]))
    else $error("replacement bit not inverted after fill");
  AST_LRU_HIT: assert property (look && hit_w == 2'b10 |=> lru_q[$past(idx)] == tmc_pkg::LRU_A)
    else $error("hit on b did not make a least recent");
  AST_CLEAR_MISS: assert property (s_clear_then_fetch |-> miss)
    else $error("lookup hit right after a clear");
  AST_FILL_HIT: assert property (s_fill_done |-> any_hit ##1 (fetch_ack_q || src_sw_q))
    else $error("filled block did not answer the lookup");
  AST_NO_MEM: assert property (look && any_hit |=> !mem_req_q && fetch_word_q == $past(hit_word))
    else $error("hit went to memory or gave the wrong word");
  AST_MISS_REQ: assert property (look && miss |=> mem_req_q && mem_addr_q == ($past(addr_q) & tmc_pkg::FILL_MASK))
    else $error("miss fill address wrong");
  AST_DUAL: assert property (look && dual |=> processor_error_report)
    else $error("double match not reported");
  AST_HOLD: assert property (state_q == tmc_pkg::S_FILL |-> !fetch_ack_q ##1 !fetch_ack_q)
    else $error("acknowledged during fill");
endmodule

/* inc/tmc_pkg.sv */
package tmc_pkg;
  // ----------------------------------------
  // fetch address layout
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int WORD_W = 16;
  localparam int KEY_W = 8;
  localparam int IDX_W = 8;
  localparam int WSEL_W = 2;
  localparam int WORDS = 4;
  localparam int BLOCK_W = WORDS * WORD_W;
  // key sits just below the two unused top bits
  localparam int KEY_LSB = 14;
  localparam int IDX_LSB = 6;
  localparam int WSEL_LSB = 4;
  // the four low bits are always zero
  localparam logic [ADDR_W-1:0] ADDR_KEEP = 24'hfffff0;
  // fill starts at the word-0 boundary
  localparam logic [ADDR_W-1:0] FILL_MASK = 24'h3fffc0;
  // clear-cache microinstruction
  localparam logic [7:0] OPC_CLEAR = 8'h5f;
  // replacement bit values naming the victim
  localparam logic LRU_A = 1'b0;
  localparam logic LRU_B = 1'b1;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_MFP = 8'h00;
  localparam logic [7:0] REG_FDATA = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_IEN = 8'h0c;
  localparam logic [7:0] REG_ICLR = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam int FDATA_VALID = 16;
  localparam int CTRL_CLEAR = 0;
  // status bits
  localparam int STAT_W = 5;
  localparam int ST_HIT = 0;
  localparam int ST_MISS = 1;
  localparam int ST_DUAL = 2;
  localparam int ST_PERR = 3;
  localparam int ST_CLR = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // sequencer states, gray along idle-look-fill-look
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOOK = 2'b01,
    S_FILL = 2'b11
  } tmc_state_e;
endpackage

/* rtl/tmc_parity.sv */
module tmc_parity #(
  parameter int W = 16,
  parameter bit ODD = 1'b0
) (
  // data in
  input wire logic [W-1:0] data,
  // parity bit that completes the chosen sense
  output logic par
);
  // odd sense inverts the plain xor
  assign par = (^data) ^ ODD;
endmodule

/* rtl/tmc_way.sv */
module tmc_way #(
  parameter int NCLASS = 256
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // lookup side
  input wire logic [7:0] rd_idx,
  input wire logic [1:0] rd_word,
  output logic [7:0] rd_key,
  output logic rd_inv,
  output logic rd_kpar,
  output logic [15:0] rd_data,
  output logic rd_dpar,
  // clear and load side
  input wire logic inv_all,
  input wire logic we,
  input wire logic [7:0] wr_idx,
  input wire logic [7:0] wr_key,
  input wire logic wr_kpar,
  input wire logic [63:0] wr_block,
  input wire logic [3:0] wr_dpar
);
  logic [7:0] key_mem [NCLASS];     // key store, no reset needed
  logic [16:0] dat_mem [NCLASS*4];  // word plus parity
  logic [NCLASS-1:0] inv_q;         // invalidity flags
  logic [NCLASS-1:0] kpar_q;        // key parity kept beside the flag

  assign rd_key = key_mem[rd_idx];
  assign rd_inv = inv_q[rd_idx];
  assign rd_kpar = kpar_q[rd_idx];
  assign rd_data = dat_mem[{rd_idx, rd_word}][15:0];
  assign rd_dpar = dat_mem[{rd_idx, rd_word}][16];

  // arrays: four words land in one edge
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      key_mem[wr_idx] <= wr_key;
      for (int i = 0; i < 4; i++)
        dat_mem[{wr_idx, 2'(i)}] <= {wr_dpar[i], wr_block[16*i +: 16]};
    end
  end

  // flags: a clear flips parity of every block that was valid,
  // so odd parity over key plus flag still holds
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      inv_q <= '1;
      kpar_q <= '0;
    end
    else if (inv_all)
    begin
      inv_q <= '1;
      kpar_q <= kpar_q ^ ~inv_q;
    end
    else if (we)
    begin
      inv_q[wr_idx] <= 1'b0;
      kpar_q[wr_idx] <= wr_kpar;
    end
  end
endmodule

/* bench/tmc_mem_model.sv */
// ----------------------------------------
// main memory fill port model
// ----------------------------------------
module tmc_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill request from the cache
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  // answer delay in cycles, zero is prompt
  input wire logic [2:0] delay,
  // fill answer
  output logic mem_ack,
  output logic [63:0] mem_block
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q; // cycles spent on the current request
  // word stored at one memory address, easy to tell apart
  function automatic logic [15:0] mw(input logic [23:0] a);
    return {a[11:4], a[19:12]} ^ 16'ha5c3;
  endfunction
  // one beat of four words; between beats the bus toggles so stale data never looks valid
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_ack <= 1'b0;
      mem_block <= '1;
      wait_q <= 3'h0;
    end
    else if (mem_req && !mem_ack && wait_q == delay)
    begin
      mem_ack <= 1'b1;
      mem_block <= {mw(mem_addr + 24'h30), mw(mem_addr + 24'h20), mw(mem_addr + 24'h10), mw(mem_addr)};
      wait_q <= 3'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_block <= ~mem_block;
      wait_q <= (mem_req && !mem_ack) ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule

/* bench/tmc_cache_tb.sv */
module tmc_cache_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 0, resetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, exec_opcode = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic fetch_req = 0, exec_valid = 0, console_clear = 0, console_load = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic fetch_ack, mem_req, mem_ack, processor_error_report, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] fetch_addr = 0, console_addr = 0, mem_addr;
  logic [63:0] console_block = 0, mem_block;
  logic [15:0] fetch_word;
  logic [2:0] delay = 0;
  int bad_count = 0, samples_checked = 0, err_exp = 0, err_seen = 0;
  // expected results, oldest first
  logic [15:0] w_q[$];
  logic [23:0] f_q[$];
  logic [33:0] r_q[$];
  logic [1:0] b_q[$];
  // reference copy of keys, flags, replacement bits and data
  logic [7:0] tk[2][256];
  bit tv[2][256];
  bit tl[256];
  logic [63:0] td[2][256];
  always #2 clk = ~clk;
  tmc_cache u_dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_req, .fetch_addr,
    .fetch_ack, .fetch_word, .exec_valid, .exec_opcode, .console_clear, .console_load, .console_addr,
    .console_block, .mem_req, .mem_addr, .mem_ack, .mem_block, .processor_error_report, .irq);
  tmc_mem_model u_mem (.clk, .resetn, .mem_req, .mem_addr, .delay, .mem_ack, .mem_block);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] mw(input logic [23:0] a);
    return {a[11:4], a[19:12]} ^ 16'ha5c3;
  endfunction
  // fetch address from key, class and word
  function automatic logic [23:0] fa(input logic [7:0] k, input logic [7:0] i, input logic [1:0] w);
    return {2'b00, k, i, w, 4'h0};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // monitor: each answer takes the oldest note; an answer with no note is a mismatch
  always @(posedge clk)
  begin
    if (processor_error_report === 1'b1) err_seen++;
    if (fetch_ack === 1'b1) chk(fetch_word, w_q.size() ? w_q.pop_front() : 'x, "fetch word");
    if (mem_ack === 1'b1) chk(mem_addr, f_q.size() ? f_q.pop_front() : 'x, "fill address");
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) chk(s_axi_bresp, b_q.size() ? b_q.pop_front() : 'x, "bresp");
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk({s_axi_rresp, s_axi_rdata}, r_q.size() ? r_q.pop_front() : 'x, "read");
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    b_q.push_back(r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    // each channel released only at the edge that takes it
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    chk(n < 100, 1, "write timeout");
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    r_q.push_back({r, d});
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 100);
    s_axi_rready <= 1'b0;
    chk(n < 100, 1, "read timeout");
  endtask
  // predicts hit, miss or dual match, notes the results, then runs the handshake
  task automatic fetch(input logic [23:0] a);
    logic [7:0] i, k;
    logic [23:0] f;
    bit ha, hb;
    int h, n;
    i = a[13:6];
    k = a[21:14];
    f = a & tmc_pkg::FILL_MASK;
    n = 0;
    ha = tv[0][i] && tk[0][i] == k;
    hb = tv[1][i] && tk[1][i] == k;
    h = ha ? 0 : 1;
    if (ha && hb) err_exp++;
    else if (ha || hb) tl[i] = !h;
    else
    begin
      h = tl[i];
      tk[h][i] = k;
      tv[h][i] = 1'b1;
      tl[i] = !tl[i];
      f_q.push_back(f);
      for (int j = 0; j < 4; j++) td[h][i][16*j +: 16] = mw(f + 24'(16 * j));
    end
    w_q.push_back(td[h][i][16*a[5:4] +: 16]);
    @(posedge clk);
    fetch_addr <= a;
    fetch_req <= 1'b1;
    do @(posedge clk);
    while (fetch_ack !== 1'b1 && ++n < 300);
    fetch_req <= 1'b0;
    chk(n < 300, 1, "fetch timeout");
  endtask
  // how: 0 clear opcode, 1 console, 2 control register, 3 other opcode (no clear)
  task automatic clr(input int how);
    if (how != 3) tv = '{default: 1'b0};
    if (how == 2) axi_wr(tmc_pkg::REG_CTRL, 32'h1 << tmc_pkg::CTRL_CLEAR, tmc_pkg::RESP_OKAY);
    else
    begin
      @(posedge clk);
      exec_valid <= how == 0 || how == 3;
      exec_opcode <= (how == 3) ? 8'h5e : tmc_pkg::OPC_CLEAR;
      console_clear <= how == 1;
      @(posedge clk);
      {exec_valid, console_clear} <= 2'b00;
    end
  endtask
  // console load picks the victim like a fill does
  task automatic cload(input logic [23:0] a, input logic [63:0] d);
    int h;
    h = tl[a[13:6]];
    tk[h][a[13:6]] = a[21:14];
    tv[h][a[13:6]] = 1'b1;
    td[h][a[13:6]] = d;
    tl[a[13:6]] = !h;
    @(posedge clk);
    console_addr <= a;
    console_block <= d;
    console_load <= 1'b1;
    @(posedge clk);
    console_load <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hb656));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    fetch(fa(8'h17, 8'd91, 2'd1));
    fetch(fa(8'h17, 8'd91, 2'd3));
    $display("test fill and hit done");
    delay <= 3'd5;
    fetch(fa(8'h24, 8'd91, 2'd0));
    fetch(fa(8'h17, 8'd91, 2'd0));
    fetch(fa(8'ha2, 8'd91, 2'd2));
    fetch(fa(8'h17, 8'd91, 2'd1));
    fetch(fa(8'h24, 8'd91, 2'd3));
    $display("test replacement done");
    for (int c = 3; c >= 0; c--)
    begin
      clr(c);
      fetch(fa(8'h17, 8'd91, 2'd0));
    end
    $display("test clear done");
    cload(fa(8'h33, 8'd92, 2'd0), {$urandom, $urandom});
    fetch(fa(8'h33, 8'd92, 2'd1));
    cload(fa(8'h17, 8'd91, 2'd0), {$urandom, $urandom});
    fetch(fa(8'h17, 8'd91, 2'd2));
    repeat (2) @(posedge clk);
    chk(err_seen, err_exp, "error pulses");
    $display("test console and dual match done");
    axi_wr(tmc_pkg::REG_ICLR, 32'h1f, tmc_pkg::RESP_OKAY);
    axi_wr(tmc_pkg::REG_IEN, 32'h0, tmc_pkg::RESP_OKAY);
    fetch(fa(8'h33, 8'd92, 2'd2));
    axi_rd(tmc_pkg::REG_STAT, 32'h1 << tmc_pkg::ST_HIT, tmc_pkg::RESP_OKAY);
    chk(irq, 0, "irq masked");
    axi_wr(tmc_pkg::REG_IEN, 32'h1 << tmc_pkg::ST_HIT, tmc_pkg::RESP_OKAY);
    axi_rd(tmc_pkg::REG_IEN, 32'h1 << tmc_pkg::ST_HIT, tmc_pkg::RESP_OKAY);
    chk(irq, 1, "irq raised");
    axi_wr(tmc_pkg::REG_ICLR, 32'h1 << tmc_pkg::ST_HIT, tmc_pkg::RESP_OKAY);
    axi_rd(tmc_pkg::REG_STAT, 32'h0, tmc_pkg::RESP_OKAY);
    chk(irq, 0, "irq cleared");
    axi_wr(8'h40, 32'h1, tmc_pkg::RESP_SLVERR);
    axi_rd(8'h40, 32'h0, tmc_pkg::RESP_SLVERR);
    axi_wr(tmc_pkg::REG_MFP, {8'h00, fa(8'h33, 8'd92, 2'd3)}, tmc_pkg::RESP_OKAY);
    axi_rd(tmc_pkg::REG_FDATA, {15'h0, 1'b1, td[0][92][63:48]}, tmc_pkg::RESP_OKAY);
    $display("test registers done");
    // few keys over few classes, so victims and hits mix at random delays
    repeat (300)
    begin
      delay <= 3'($urandom % 8);
      fetch(fa(8'h10 + 8'($urandom % 4), 8'd100 + 8'($urandom % 4), 2'($urandom % 4)));
    end
    $display("test random traffic done");
    repeat (4) @(posedge clk);
    chk(w_q.size() + f_q.size() + r_q.size() + b_q.size(), 0, "notes left over");
    wrap_up;
  end
  // watchdog sized well above the expected run
  initial
  begin
    #100000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
